// File: usb_hs_pkg.sv
package usb_hs_pkg;

  // byte addresses of the mapped words
  localparam logic [31:0] CTRL_ADDR = 32'h400a4000;
  localparam logic [31:0] FNUM_ADDR = 32'h400a4004;
  localparam logic [31:0] IEN_ADDR = 32'h400a4010;
  localparam logic [31:0] STA_ADDR = 32'h400a4014;
  localparam logic [31:0] CLR_ADDR = 32'h400a4018;

  // control word fields
  localparam int EN_BIT = 8;
  localparam int DETACH_BIT = 9;
  localparam int WAKE_BIT = 10;
  localparam int PDDIS_BIT = 11;
  localparam logic [31:0] CTRL_RESET = 32'h00000200;

  // frame number word fields
  localparam int MICRO_LO = 0;
  localparam int FRAME_LO = 3;
  localparam int FERR_BIT = 31;

  // status / enable / clear fields
  localparam int SPEED_BIT = 0;
  localparam int SUSP_BIT = 1;
  localparam int MSOF_BIT = 2;
  localparam int SOF_BIT = 3;
  localparam int ERST_BIT = 4;
  localparam int WAKEUP_BIT = 5;
  localparam int ERSM_BIT = 6;
  localparam int UPRES_BIT = 7;
  localparam int EPT_LO = 8;
  localparam int DMA_LO = 25;
  localparam logic [31:0] IEN_MASK = 32'h7e007ffe;
  localparam logic [31:0] IEN_RESET = 32'h00000010;

  localparam logic [1:0] LINE_J = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // times and derived cycle counts
  localparam int CLK_MHZ = 25;
  localparam int SUSPEND_MS = 3;
  localparam int WAKE_WAIT_MS = 5;
  localparam int RESUME_MS = 2;
  localparam int FRAME_US = 1000;
  localparam int MICRO_US = 125;
  localparam int SUSPEND_CYC = SUSPEND_MS * 1000 * CLK_MHZ;
  localparam int WAKE_WAIT_CYC = WAKE_WAIT_MS * 1000 * CLK_MHZ;
  localparam int RESUME_CYC = RESUME_MS * 1000 * CLK_MHZ;
  localparam int FRAME_CYC = FRAME_US * CLK_MHZ;
  localparam int MICRO_CYC = MICRO_US * CLK_MHZ;

  typedef logic [17:0] cnt_t;
  typedef enum logic [1:0] {WK_IDLE, WK_DRIVE} wake_e;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_s;

  typedef struct packed {
    logic [1:0] lineState;
    logic hsMode;
    logic sofValid;
    logic [10:0] sofFrame;
    logic sofCrcErr;
    logic busResetEnd;
    logic hostResumeEnd;
  } utmi_in_s;

  typedef struct packed {
    logic xcvrEnable;
    logic suspendN;
    logic dpPullUp;
    logic dpPullDown;
    logic dmPullDown;
    logic driveResumeK;
  } utmi_out_s;

endpackage

// File: usb_hs_device_global_control.sv
`timescale 1ns/1ns
module usb_hs_device_global_control #(
  parameter int SUSPEND_CYC = usb_hs_pkg::SUSPEND_CYC,
  parameter int WAKE_WAIT_CYC = usb_hs_pkg::WAKE_WAIT_CYC,
  parameter int RESUME_CYC = usb_hs_pkg::RESUME_CYC,
  parameter int FRAME_CYC = usb_hs_pkg::FRAME_CYC,
  parameter int MICRO_CYC = usb_hs_pkg::MICRO_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire usb_hs_pkg::axi_req_s axiReq,
  output usb_hs_pkg::axi_rsp_s axiRsp,
  input wire usb_hs_pkg::utmi_in_s utmiIn,
  output usb_hs_pkg::utmi_out_s utmiOut,
  input wire logic [6:0] eptIrqSrc,
  input wire logic [5:0] dmaIrqSrc,
  output logic irq
);

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // bus slave

  usb_hs_pkg::axi_rsp_s rsp_q, rsp_d;
  logic awHave_q, awHave_d, wHave_q, wHave_d;
  logic [31:0] awAddr_q, awAddr_d, wData_q, wData_d;
  logic [3:0] wStrb_q, wStrb_d;
  logic doWrite;
  logic [31:0] rdWord;
  logic rdHit;
  logic [31:0] ctrlWord, fnumWord, ienWord, staWord;

  always_comb begin
    rdHit = 1'b1;
    case (axiReq.araddr)
      usb_hs_pkg::CTRL_ADDR: rdWord = ctrlWord;
      usb_hs_pkg::FNUM_ADDR: rdWord = fnumWord;
      usb_hs_pkg::IEN_ADDR: rdWord = ienWord;
      usb_hs_pkg::STA_ADDR: rdWord = staWord;
      usb_hs_pkg::CLR_ADDR: rdWord = 32'h00000000;
      default: begin
        rdWord = 32'h00000000;
        rdHit = 1'b0;
      end
    endcase
  end

  always_comb begin
    rsp_d = rsp_q;
    awHave_d = awHave_q;
    awAddr_d = awAddr_q;
    wHave_d = wHave_q;
    wData_d = wData_q;
    wStrb_d = wStrb_q;
    doWrite = awHave_q && wHave_q && !rsp_q.bvalid;
    if (rsp_q.bvalid && axiReq.bready) begin
      rsp_d.bvalid = 1'b0;
    end
    if (doWrite) begin
      awHave_d = 1'b0;
      wHave_d = 1'b0;
      rsp_d.bvalid = 1'b1;
      case (awAddr_q)
        usb_hs_pkg::CTRL_ADDR, usb_hs_pkg::FNUM_ADDR, usb_hs_pkg::IEN_ADDR,
        usb_hs_pkg::STA_ADDR, usb_hs_pkg::CLR_ADDR:
          rsp_d.bresp = usb_hs_pkg::RESP_OKAY;
        default: rsp_d.bresp = usb_hs_pkg::RESP_SLVERR;
      endcase
    end
    // address and data are taken in either order
    if (axiReq.awvalid && rsp_q.awready) begin
      awHave_d = 1'b1;
      awAddr_d = axiReq.awaddr;
    end
    if (axiReq.wvalid && rsp_q.wready) begin
      wHave_d = 1'b1;
      wData_d = axiReq.wdata;
      wStrb_d = axiReq.wstrb;
    end
    if (rsp_q.rvalid && axiReq.rready) begin
      rsp_d.rvalid = 1'b0;
    end
    if (axiReq.arvalid && rsp_q.arready) begin
      rsp_d.rvalid = 1'b1;
      rsp_d.rdata = rdWord;
      rsp_d.rresp = rdHit ? usb_hs_pkg::RESP_OKAY : usb_hs_pkg::RESP_SLVERR;
    end
    rsp_d.awready = !awHave_d && !rsp_d.bvalid;
    rsp_d.wready = !wHave_d && !rsp_d.bvalid;
    rsp_d.arready = !rsp_d.rvalid;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rsp_q <= '0;
      awHave_q <= 1'b0;
      awAddr_q <= 32'h00000000;
      wHave_q <= 1'b0;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
    end else begin
      rsp_q <= rsp_d;
      awHave_q <= awHave_d;
      awAddr_q <= awAddr_d;
      wHave_q <= wHave_d;
      wData_q <= wData_d;
      wStrb_q <= wStrb_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control and enable words

  logic [31:0] ctrl_q, ctrl_d, ien_q, ien_d, wrWord, clrWord;
  logic wakeClr;

  always_comb begin
    wrWord = 32'h00000000;
    clrWord = 32'h00000000;
    ctrl_d = ctrl_q;
    ien_d = ien_q;
    if (doWrite && awAddr_q == usb_hs_pkg::CLR_ADDR) begin
      clrWord = merge(32'h00000000, wData_q, wStrb_q);
    end
    if (wakeClr) begin
      ctrl_d[usb_hs_pkg::WAKE_BIT] = 1'b0;
    end
    if (doWrite && awAddr_q == usb_hs_pkg::CTRL_ADDR) begin
      wrWord = merge(ctrl_q, wData_q, wStrb_q);
      ctrl_d[usb_hs_pkg::EN_BIT] = wrWord[usb_hs_pkg::EN_BIT];
      ctrl_d[usb_hs_pkg::DETACH_BIT] = wrWord[usb_hs_pkg::DETACH_BIT];
      ctrl_d[usb_hs_pkg::PDDIS_BIT] = wrWord[usb_hs_pkg::PDDIS_BIT];
      // a zero written here leaves a pending request alone
      if (wrWord[usb_hs_pkg::WAKE_BIT]) begin
        ctrl_d[usb_hs_pkg::WAKE_BIT] = 1'b1;
      end
    end
    if (doWrite && awAddr_q == usb_hs_pkg::IEN_ADDR) begin
      ien_d = merge(ien_q, wData_q, wStrb_q) & usb_hs_pkg::IEN_MASK;
    end
    if (utmiIn.busResetEnd) begin
      ien_d[usb_hs_pkg::ERST_BIT] = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_q <= usb_hs_pkg::CTRL_RESET;
      ien_q <= usb_hs_pkg::IEN_RESET;
    end else begin
      ctrl_q <= ctrl_d;
      ien_q <= ien_d;
    end
  end

  logic enable, detach, pdDis;
  assign enable = ctrl_q[usb_hs_pkg::EN_BIT];
  assign detach = ctrl_q[usb_hs_pkg::DETACH_BIT];
  assign pdDis = ctrl_q[usb_hs_pkg::PDDIS_BIT];

  ////////////////////////////////////////////////////////////////////////
  // frame tracking

  logic [2:0] micro_q, micro_d;
  logic [10:0] frame_q, frame_d;
  logic ferr_q, ferr_d, hs_q;
  usb_hs_pkg::cnt_t tmr_q, tmr_d, period;
  logic setSof, setMicro, suspended_q;

  always_comb begin
    setSof = 1'b0;
    setMicro = 1'b0;
    micro_d = micro_q;
    frame_d = frame_q;
    ferr_d = ferr_q;
    tmr_d = usb_hs_pkg::cnt_t'(tmr_q + 18'h00001);
    period = hs_q ? usb_hs_pkg::cnt_t'(MICRO_CYC) :
        usb_hs_pkg::cnt_t'(FRAME_CYC);
    if (utmiIn.sofValid) begin
      tmr_d = '0;
      ferr_d = utmiIn.sofCrcErr;
      // a new frame number marks the first microframe of a frame
      if (!hs_q || (!utmiIn.sofCrcErr && utmiIn.sofFrame != frame_q)) begin
        setSof = 1'b1;
        micro_d = 3'h0;
        if (!utmiIn.sofCrcErr) begin
          frame_d = utmiIn.sofFrame;
        end
      end else begin
        setMicro = 1'b1;
        micro_d = 3'(micro_q + 3'h1);
      end
    // >= so a count left from the longer full-speed period cannot stall
    end else if (!suspended_q && tmr_q >= usb_hs_pkg::cnt_t'(period - 1)) begin
      // synthesized start of (micro)frame when the host is missed
      tmr_d = '0;
      if (hs_q && micro_q != 3'h7) begin
        setMicro = 1'b1;
        micro_d = 3'(micro_q + 3'h1);
      end else begin
        setSof = 1'b1;
        micro_d = 3'h0;
      end
    end
    if (utmiIn.busResetEnd) begin
      micro_d = 3'h0;
      frame_d = 11'h000;
      ferr_d = 1'b0;
      tmr_d = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n || !enable) begin
      micro_q <= 3'h0;
      frame_q <= 11'h000;
      ferr_q <= 1'b0;
      tmr_q <= '0;
      hs_q <= 1'b0;
    end else begin
      micro_q <= micro_d;
      frame_q <= frame_d;
      ferr_q <= ferr_d;
      tmr_q <= tmr_d;
      hs_q <= utmiIn.hsMode;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // suspend and remote wakeup

  usb_hs_pkg::wake_e wk_q, wk_d;
  usb_hs_pkg::cnt_t idle_q, idle_d, sus_q, sus_d, res_q, res_d;
  logic suspended_d, setSusp, setWake, setErsm, setUp, wakeOk;

  assign wakeOk = sus_q == usb_hs_pkg::cnt_t'(WAKE_WAIT_CYC - 1);

  always_comb begin
    wk_d = wk_q;
    idle_d = '0;
    sus_d = '0;
    res_d = '0;
    suspended_d = suspended_q;
    setSusp = 1'b0;
    setWake = 1'b0;
    setErsm = 1'b0;
    setUp = 1'b0;
    wakeClr = 1'b0;
    if (!suspended_q) begin
      if (utmiIn.lineState == usb_hs_pkg::LINE_J && !utmiIn.sofValid) begin
        idle_d = usb_hs_pkg::cnt_t'(idle_q + 18'h00001);
        if (idle_q == usb_hs_pkg::cnt_t'(SUSPEND_CYC - 1)) begin
          setSusp = 1'b1;
          suspended_d = 1'b1;
          idle_d = '0;
        end
      end
    end else begin
      sus_d = wakeOk ? sus_q : usb_hs_pkg::cnt_t'(sus_q + 18'h00001);
    end
    case (wk_q)
      usb_hs_pkg::WK_IDLE: begin
        if (suspended_q && ctrl_q[usb_hs_pkg::WAKE_BIT] && wakeOk) begin
          wk_d = usb_hs_pkg::WK_DRIVE;
          setUp = 1'b1;
        end else if (suspended_q &&
            utmiIn.lineState != usb_hs_pkg::LINE_J) begin
          setWake = 1'b1;
          suspended_d = 1'b0;
        end
      end
      usb_hs_pkg::WK_DRIVE: begin
        res_d = usb_hs_pkg::cnt_t'(res_q + 18'h00001);
        if (res_q == usb_hs_pkg::cnt_t'(RESUME_CYC - 1)) begin
          wk_d = usb_hs_pkg::WK_IDLE;
          wakeClr = 1'b1;
          suspended_d = 1'b0;
          res_d = '0;
        end
      end
      default: wk_d = usb_hs_pkg::WK_IDLE;
    endcase
    if (utmiIn.hostResumeEnd) begin
      setErsm = 1'b1;
      suspended_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n || !enable) begin
      wk_q <= usb_hs_pkg::WK_IDLE;
      idle_q <= '0;
      sus_q <= '0;
      res_q <= '0;
      suspended_q <= 1'b0;
    end else begin
      wk_q <= wk_d;
      idle_q <= idle_d;
      sus_q <= sus_d;
      res_q <= res_d;
      suspended_q <= suspended_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flags, interrupt and transceiver controls

  logic [7:1] flag_q, flag_d, flagSet;
  logic [6:0] ept_q;
  logic [5:0] dma_q;
  logic irq_q;
  usb_hs_pkg::utmi_out_s out_q, out_d;

  always_comb begin
    flagSet = {setUp, setErsm, setWake, utmiIn.busResetEnd, setSof,
        setMicro, setSusp};
    flag_d = (flag_q & ~clrWord[7:1]) | flagSet;
  end

  assign staWord = {1'b0, dma_q, 10'h000, ept_q, flag_q, hs_q};
  assign ienWord = ien_q;
  assign fnumWord = {ferr_q, 17'h00000, frame_q, micro_q};
  assign ctrlWord = ctrl_q;

  always_comb begin
    out_d.xcvrEnable = enable;
    out_d.driveResumeK = enable && wk_q == usb_hs_pkg::WK_DRIVE;
    // detached or disabled parts hold the transceiver in suspend
    out_d.suspendN = enable && !detach && !(suspended_q &&
        wk_q == usb_hs_pkg::WK_IDLE);
    out_d.dpPullUp = enable && !detach;
    out_d.dpPullDown = detach && !pdDis;
    out_d.dmPullDown = !pdDis;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n || !enable) begin
      flag_q <= 7'h00;
      ept_q <= 7'h00;
      dma_q <= 6'h00;
      irq_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
      // endpoint and channel bits follow their sources, gated by enable
      ept_q <= eptIrqSrc & ien_q[usb_hs_pkg::EPT_LO +: 7];
      dma_q <= dmaIrqSrc & ien_q[usb_hs_pkg::DMA_LO +: 6];
      irq_q <= |(staWord[31:1] & ien_q[31:1]);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      out_q <= '0;
    end else begin
      out_q <= out_d;
    end
  end

  assign axiRsp = rsp_q;
  assign utmiOut = out_q;
  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_resume_end;
    wk_q == usb_hs_pkg::WK_DRIVE && res_q == usb_hs_pkg::cnt_t'(RESUME_CYC - 1);
  endsequence

  property p_disable;
    !enable |=> !utmiOut.xcvrEnable && !utmiOut.dpPullUp;
  endproperty
  a_disable: assert property (p_disable) else $error("xcvr not off");
  property p_detach;
    enable && detach |=> !utmiOut.suspendN && !utmiOut.dpPullUp;
  endproperty
  a_detach: assert property (p_detach) else $error("detach ignored");
  property p_wake_wait;
    $rose(out_d.driveResumeK) && enable |-> wakeOk && suspended_q;
  endproperty
  a_wake_wait: assert property (p_wake_wait) else $error("early resume");
  property p_wake_clr;
    s_resume_end ##0 !(doWrite && awAddr_q == usb_hs_pkg::CTRL_ADDR) |=>
        !ctrl_q[usb_hs_pkg::WAKE_BIT];
  endproperty
  a_wake_clr: assert property (p_wake_clr) else $error("wake stuck");
  property p_hiz;
    detach && pdDis |=> !utmiOut.dpPullUp && !utmiOut.dpPullDown &&
        !utmiOut.dmPullDown;
  endproperty
  a_hiz: assert property (p_hiz) else $error("lines not floating");
  property p_ferr;
    enable && utmiIn.sofValid && !utmiIn.busResetEnd |=>
        ferr_q == $past(utmiIn.sofCrcErr) && (flag_q[3] || flag_q[2]);
  endproperty
  a_ferr: assert property (p_ferr) else $error("ferr not in step");
  property p_one_sof;
    !(setSof && setMicro);
  endproperty
  a_one_sof: assert property (p_one_sof) else $error("both sof flags");
  property p_ien_reset;
    utmiIn.busResetEnd |=> ien_q[usb_hs_pkg::ERST_BIT];
  endproperty
  a_ien_reset: assert property (p_ien_reset) else $error("ien not set");
  property p_micro_clr;
    enable && setSof && !utmiIn.busResetEnd |=> micro_q == 3'h0;
  endproperty
  a_micro_clr: assert property (p_micro_clr) else $error("micro kept");
  property p_irq;
    enable && |(staWord[31:1] & ien_q[31:1]) ##1 enable |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");
  property p_susp;
    enable && setSusp |-> idle_q == usb_hs_pkg::cnt_t'(SUSPEND_CYC - 1)
        ##1 flag_q[1] || !enable;
  endproperty
  a_susp: assert property (p_susp) else $error("suspend flag");
  property p_clear;
    enable && clrWord[3] && !setSof ##1 enable |-> !flag_q[3];
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");

endmodule // usb_hs_device_global_control

// File: utmi_host_model.sv
`timescale 1ns/1ns
module utmi_host_model (
  input wire logic core_clk,
  input wire usb_hs_pkg::utmi_out_s utmiOut,
  output usb_hs_pkg::utmi_in_s utmiIn
);
  logic idle = 1'b0;
  logic tog = 1'b0;
  initial utmiIn = '0;
  ////////////////////////////////////////////////////////////////////////////
  // busy bus toggles so the idle timer never runs out by accident
  always @(posedge core_clk) begin
    tog <= ~tog;
    if (utmiOut.driveResumeK) begin
      utmiIn.lineState <= 2'h2;
    end else if (idle) begin
      utmiIn.lineState <= usb_hs_pkg::LINE_J;
    end else begin
      utmiIn.lineState <= tog ? usb_hs_pkg::LINE_J : 2'h2;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // token fields go stale after the pulse, not left at the last value
  task automatic sof(input logic [10:0] f, input logic e);
    @(posedge core_clk);
    utmiIn.sofValid <= 1'b1;
    utmiIn.sofFrame <= f;
    utmiIn.sofCrcErr <= e;
    @(posedge core_clk);
    utmiIn.sofValid <= 1'b0;
    utmiIn.sofFrame <= ~f;
    utmiIn.sofCrcErr <= ~e;
  endtask
  task automatic resetEnd();
    @(posedge core_clk);
    utmiIn.busResetEnd <= 1'b1;
    @(posedge core_clk);
    utmiIn.busResetEnd <= 1'b0;
  endtask
  task automatic resumeEnd();
    @(posedge core_clk);
    utmiIn.hostResumeEnd <= 1'b1;
    @(posedge core_clk);
    utmiIn.hostResumeEnd <= 1'b0;
  endtask
endmodule // utmi_host_model

// File: usb_hs_device_global_control_bench.sv
`timescale 1ns/1ns
module usb_hs_device_global_control_bench;
  localparam int SUSP = 40;
  localparam int WAKE = 60;
  localparam int RES = 20;
  localparam int MIC = 400;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  usb_hs_pkg::axi_req_s req = '0;
  usb_hs_pkg::axi_rsp_s rsp;
  usb_hs_pkg::utmi_in_s uIn;
  usb_hs_pkg::utmi_out_s uOut;
  logic [6:0] ept = '0;
  logic [5:0] dma = '0;
  logic irq;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int cnt;
  int tSusp;
  int mMicro;
  logic [10:0] frames[$];
  logic [31:0] rdv;
  logic [1:0] rsv;
  logic [31:0] en;
  logic [10:0] f0;
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;
  ////////////////////////////////////////////////////////////////////////////
  usb_hs_device_global_control #(
    .SUSPEND_CYC(SUSP),
    .WAKE_WAIT_CYC(WAKE),
    .RESUME_CYC(RES),
    .FRAME_CYC(8 * MIC),
    .MICRO_CYC(MIC)
  ) usb_hs_device_global_control_inst (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .axiReq(req),
    .axiRsp(rsp),
    .utmiIn(uIn),
    .utmiOut(uOut),
    .eptIrqSrc(ept),
    .dmaIrqSrc(dma),
    .irq(irq)
  );
  utmi_host_model utmi_host_model_inst (
    .core_clk(core_clk),
    .utmiOut(uOut),
    .utmiIn(uIn)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, exp, input string m);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic hang();
    errors++;
    $display("BAD %0t no answer", $time);
    summarize();
  endtask
  // valids drop at the edge they are taken, so aw and w may land apart
  task automatic wr(input logic [31:0] a, d);
    int i;
    @(posedge core_clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    rsv = rsp.bresp;
    req.bready <= 1'b0;
    if (i == 50) hang();
  endtask
  task automatic rd(input logic [31:0] a);
    int i;
    @(posedge core_clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk);
      if (rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) break;
    end
    rdv = rsp.rdata;
    rsv = rsp.rresp;
    req.rready <= 1'b0;
    if (i == 50) hang();
  endtask
  // one token, then flags and frame word against the model
  task automatic sofStep(input logic [10:0] f, input logic e, s);
    wr(usb_hs_pkg::CLR_ADDR, 32'h0000000c);
    utmi_host_model_inst.sof(f, e);
    tick(2);
    if (s) mMicro = 0;
    else mMicro++;
    if (s && !e) frames.push_back(f);
    rd(usb_hs_pkg::STA_ADDR);
    chk(rdv[3:0], {s, !s, 1'b0, uIn.hsMode}, "sof flags");
    rd(usb_hs_pkg::FNUM_ADDR);
    chk(rdv, {e, 17'h0, frames[$], mMicro[2:0]}, "frame word");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #300000;
    hang();
  end
  initial begin
    cnt = $urandom(32'h5ce0);
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    tick(2);
    rd(usb_hs_pkg::CTRL_ADDR);
    chk(rdv, usb_hs_pkg::CTRL_RESET, "ctrl reset");
    rd(usb_hs_pkg::IEN_ADDR);
    chk(rdv, usb_hs_pkg::IEN_RESET, "ien reset");
    rd(usb_hs_pkg::FNUM_ADDR);
    chk(rdv, 32'h0, "fnum reset");
    rd(32'h400a4008);
    chk(rsv, usb_hs_pkg::RESP_SLVERR, "unmapped resp");
    chk(rdv, 32'h0, "unmapped data");
    wr(usb_hs_pkg::STA_ADDR, 32'hffffffff);
    chk(rsv, usb_hs_pkg::RESP_OKAY, "ro write");
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      en = 32'h100 | (k[0] << 9) | (k[1] << 11);
      wr(usb_hs_pkg::CTRL_ADDR, en);
      tick(4);
      chk({uOut.xcvrEnable, uOut.suspendN, uOut.dpPullUp, uOut.dpPullDown,
        uOut.dmPullDown}, {1'b1, !k[0], !k[0], k[0] & !k[1], !k[1]},
        "terminations");
      rd(usb_hs_pkg::CTRL_ADDR);
      chk(rdv, en, "ctrl readback");
    end
    wr(usb_hs_pkg::CTRL_ADDR, 32'h100);
    $display("test terminations done");
    f0 = 11'(1 + $urandom % 2000);
    frames.push_back(11'h000);
    // full speed first: every token is a frame start
    sofStep(f0 - 11'h001, 1'b0, 1'b1);
    utmi_host_model_inst.utmiIn.hsMode <= 1'b1;
    sofStep(f0, 1'b0, 1'b1);
    repeat (3) sofStep(f0, 1'b0, 1'b0);
    sofStep(f0 + 1, 1'b1, 1'b0);
    sofStep(f0 + 1, 1'b0, 1'b1);
    // no token for a microframe: one synthesized micro SOF
    wr(usb_hs_pkg::CLR_ADDR, 32'h0000000c);
    tick(MIC);
    mMicro++;
    rd(usb_hs_pkg::STA_ADDR);
    chk(rdv[3:2], 2'b01, "synth micro");
    rd(usb_hs_pkg::FNUM_ADDR);
    chk(rdv, {18'h0, frames[$], mMicro[2:0]}, "synth frame");
    repeat (6) sofStep(f0 + 1, 1'b0, 1'b0);
    $display("test frames done");
    wr(usb_hs_pkg::IEN_ADDR, 32'h0);
    utmi_host_model_inst.resetEnd();
    tick(3);
    rd(usb_hs_pkg::IEN_ADDR);
    chk(rdv, 32'h10, "auto enable");
    rd(usb_hs_pkg::STA_ADDR);
    chk(rdv[4], 1'b1, "end reset flag");
    tick(2);
    chk(irq, 1'b1, "irq set");
    wr(usb_hs_pkg::CLR_ADDR, 32'h10);
    tick(3);
    rd(usb_hs_pkg::STA_ADDR);
    chk(rdv[4], 1'b0, "end reset clear");
    chk(irq, 1'b0, "irq clear");
    $display("test bus reset done");
    for (int k = 0; k < 4; k++) begin
      en = $urandom;
      wr(usb_hs_pkg::IEN_ADDR, en);
      rd(usb_hs_pkg::IEN_ADDR);
      chk(rdv, en & usb_hs_pkg::IEN_MASK, "ien mask");
      en = en & 32'h7e007f00;
      wr(usb_hs_pkg::IEN_ADDR, en);
      ept <= 7'($urandom);
      dma <= 6'($urandom);
      tick(4);
      rd(usb_hs_pkg::STA_ADDR);
      chk(rdv[14:8], ept & en[14:8], "ept bits");
      chk(rdv[30:25], dma & en[30:25], "dma bits");
      chk(irq, |{ept & en[14:8], dma & en[30:25]}, "src irq");
    end
    ept <= '0;
    dma <= '0;
    $display("test sources done");
    wr(usb_hs_pkg::CLR_ADDR, 32'hfe);
    utmi_host_model_inst.idle <= 1'b1;
    for (cnt = 0; cnt < 200 && uOut.suspendN !== 1'b0; cnt++) tick(1);
    tSusp = cyc;
    chk(cnt >= SUSP - 1 && cnt <= SUSP + 4, 1'b1, "suspend time");
    rd(usb_hs_pkg::STA_ADDR);
    chk(rdv[1], 1'b1, "suspend flag");
    wr(usb_hs_pkg::CTRL_ADDR, 32'h500);
    wr(usb_hs_pkg::CTRL_ADDR, 32'h100);
    rd(usb_hs_pkg::CTRL_ADDR);
    chk(rdv[10], 1'b1, "wake kept");
    for (cnt = 0; cnt < 300 && uOut.driveResumeK !== 1'b1; cnt++) tick(1);
    chk(cyc - tSusp >= WAKE - 2 && cnt < 300, 1'b1, "resume early");
    for (cnt = 0; cnt < 100 && uOut.driveResumeK === 1'b1; cnt++) tick(1);
    chk(cnt, RES, "resume length");
    tick(3);
    rd(usb_hs_pkg::CTRL_ADDR);
    chk(rdv[10], 1'b0, "wake cleared");
    rd(usb_hs_pkg::STA_ADDR);
    chk(rdv[7], 1'b1, "upstream flag");
    // host resume ends a second suspend, line activity a third
    for (cnt = 0; cnt < 200 && uOut.suspendN !== 1'b0; cnt++) tick(1);
    chk(cnt < 200, 1'b1, "no resuspend");
    utmi_host_model_inst.resumeEnd();
    tick(3);
    rd(usb_hs_pkg::STA_ADDR);
    chk(rdv[6], 1'b1, "end resume flag");
    for (cnt = 0; cnt < 200 && uOut.suspendN !== 1'b0; cnt++) tick(1);
    chk(cnt < 200, 1'b1, "no third suspend");
    utmi_host_model_inst.idle <= 1'b0;
    tick(4);
    rd(usb_hs_pkg::STA_ADDR);
    chk(rdv[5], 1'b1, "wake flag");
    $display("test wakeup done");
    // disable acts as a reset of flags and frame state
    wr(usb_hs_pkg::CTRL_ADDR, 32'h200);
    tick(4);
    chk(uOut.xcvrEnable, 1'b0, "xcvr off");
    rd(usb_hs_pkg::STA_ADDR);
    chk(rdv[7:1], 7'h0, "flags reset");
    rd(usb_hs_pkg::FNUM_ADDR);
    chk(rdv, 32'h0, "frame reset");
    $display("test disable done");
    summarize();
  end
endmodule // usb_hs_device_global_control_bench
